// ==== dv/ircw_core_model.sv ====
// partner model: core registers and program counter facing the irq block
`timescale 1ns/1ps
`default_nettype none

module ircw_core_model
  import ircw_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mutate,
  input  wire logic        core_instr_tick,
  input  wire logic        vector_load,
  input  wire logic [14:0] vector_addr,
  input  wire logic        restore_valid,
  input  wire logic [7:0]  restore_w,
  input  wire logic [7:0]  restore_status,
  input  wire logic [4:0]  restore_bnk,
  input  wire logic [15:0] restore_ptr0,
  input  wire logic [15:0] restore_ptr1,
  input  wire logic [6:0]  restore_pchigh,
  output logic      [14:0] core_pc,
  output logic      [7:0]  core_w,
  output logic      [7:0]  core_status,
  output logic      [4:0]  core_bnk,
  output logic      [15:0] core_ptr0,
  output logic      [15:0] core_ptr1,
  output logic      [6:0]  core_pchigh
);
  ////////////////////////////////////////////////////////////////////////////////
  // status starts with bits 4 and 3 set so a save that copies them shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_pc     <= 15'h0100;
      core_w      <= 8'h3c;
      core_status <= 8'h1d;
      core_bnk    <= 5'h1f;
      core_ptr0   <= 16'h1234;
      core_ptr1   <= 16'h5678;
      core_pchigh <= 7'h2a;
    end else if (restore_valid) begin
      core_w      <= restore_w;
      core_status <= restore_status;
      core_bnk    <= restore_bnk;
      core_ptr0   <= restore_ptr0;
      core_ptr1   <= restore_ptr1;
      core_pchigh <= restore_pchigh;
    end else if (mutate) begin
      core_w      <= ~core_w;
      core_status <= core_status ^ 8'h07;
      core_bnk    <= core_bnk + 5'h01;
      core_ptr0   <= ~core_ptr0;
      core_ptr1   <= ~core_ptr1;
      core_pchigh <= core_pchigh + 7'h01;
    end
    if (presetn && vector_load) begin
      core_pc <= vector_addr;
    end else if (presetn && core_instr_tick) begin
      core_pc <= core_pc + 15'h0001;
    end
  end
endmodule : ircw_core_model

`default_nettype wire

// ==== dv/ircw_ctrl_monitor.sv ====
// checker: entry, return, sleep, tick and apb timing at the block ports
`timescale 1ns/1ps
`default_nettype none

module ircw_ctrl_monitor #(
  parameter int CLKS_PER_INSTR = 4
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        core_sleep,
  input wire logic        core_return_from_irq,
  input wire logic [14:0] core_pc,
  input wire logic [7:0]  core_status,
  input wire logic        core_asleep,
  input wire logic        core_wake,
  input wire logic        core_instr_tick,
  input wire logic        core_flush,
  input wire logic        stack_push,
  input wire logic [14:0] stack_push_pc,
  input wire logic        vector_load,
  input wire logic [14:0] vector_addr,
  input wire logic        restore_valid,
  input wire logic [7:0]  restore_status
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] gap_q;
  ////////////////////////////////////////////////////////////////////////////////
  // cycles since last tick; zero until the first tick, so no false gap after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 8'h00;
    end else if (core_instr_tick) begin
      gap_q <= 8'h01;
    end else if (gap_q != 8'h00) begin
      gap_q <= gap_q + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_tick; core_instr_tick && gap_q != 8'h00 |-> gap_q == 8'(CLKS_PER_INSTR); endproperty
  a_tick: assert property (p_tick) else $error("tick spacing wrong");
  property p_flush; core_flush || stack_push |-> core_flush && stack_push; endproperty
  a_flush: assert property (p_flush) else $error("flush and push apart");
  property p_vec;
    stack_push |=> !vector_load [*3] ##1 (vector_load && vector_addr == 15'h0004);
  endproperty
  a_vec: assert property (p_vec) else $error("vector load late or wrong");
  property p_push_pc; stack_push |-> stack_push_pc == $past(core_pc); endproperty
  a_push_pc: assert property (p_push_pc) else $error("pushed pc wrong");
  property p_nest; stack_push |=> !stack_push [*8]; endproperty
  a_nest: assert property (p_nest) else $error("nested entry");
  property p_ret; restore_valid |-> $past(core_return_from_irq); endproperty
  a_ret: assert property (p_ret) else $error("restore without return");
  property p_keep;
    restore_valid |-> (restore_status & 8'h18) == ($past(core_status) & 8'h18);
  endproperty
  a_keep: assert property (p_keep) else $error("expiry or powerdown restored");
  property p_sleep; $rose(core_asleep) |-> $past(core_sleep); endproperty
  a_sleep: assert property (p_sleep) else $error("sleep without request");
  property p_wake; core_wake |-> !core_asleep && $past(core_asleep); endproperty
  a_wake: assert property (p_wake) else $error("wake while not asleep");
  property p_step; core_wake |-> !stack_push [*4]; endproperty
  a_step: assert property (p_step) else $error("entry before post-sleep step");
  property p_apb; psel && !penable |=> pready ##1 !pready; endproperty
  a_apb: assert property (p_apb) else $error("apb answer timing");
endmodule : ircw_ctrl_monitor

bind ircw_ctrl ircw_ctrl_monitor #(.CLKS_PER_INSTR(CLKS_PER_INSTR)) u_mon (
  .pclk, .presetn, .psel, .penable, .pready, .core_sleep, .core_return_from_irq,
  .core_pc, .core_status, .core_asleep, .core_wake, .core_instr_tick, .core_flush,
  .stack_push, .stack_push_pc, .vector_load, .vector_addr, .restore_valid, .restore_status
);

`default_nettype wire

// ==== dv/irq_ctrl_wake_context_test.sv ====
// testbench: registers, flags, edge pin, entry, return, sleep and wake
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; $display("unexpected %s: expected %0h, seen %0h", nm, e, g); end end

module irq_ctrl_wake_context_test
  import ircw_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, ext_irq_pin, timer0_overflow, err;
  logic        pin_change_any, core_sleep, core_return_from_irq, mutate, pready, pslverr;
  logic        core_asleep, core_wake, core_instr_tick, core_flush, stack_push;
  logic        vector_load, restore_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  periph_flags, core_w, core_status, restore_w, restore_status, r, last_rw;
  logic [4:0]  core_bnk, restore_bnk;
  logic [15:0] core_ptr0, core_ptr1, restore_ptr0, restore_ptr1;
  logic [6:0]  core_pchigh, restore_pchigh;
  logic [14:0] core_pc, stack_push_pc, vector_addr, last_vec;
  int          errors, num_checks, seed, cnt[4];

  ircw_ctrl #(.CLKS_PER_INSTR(4)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext_irq_pin, .timer0_overflow, .pin_change_any, .periph_flags, .core_sleep,
    .core_return_from_irq, .core_pc, .core_w, .core_status, .core_bnk, .core_ptr0,
    .core_ptr1, .core_pchigh, .core_asleep, .core_wake, .core_instr_tick, .core_flush,
    .stack_push, .stack_push_pc, .vector_load, .vector_addr, .restore_valid, .restore_w,
    .restore_status, .restore_bnk, .restore_ptr0, .restore_ptr1, .restore_pchigh);
  ircw_core_model u_core (
    .pclk, .presetn, .mutate, .core_instr_tick, .vector_load, .vector_addr, .restore_valid,
    .restore_w, .restore_status, .restore_bnk, .restore_ptr0, .restore_ptr1,
    .restore_pchigh, .core_pc, .core_w, .core_status, .core_bnk, .core_ptr0, .core_ptr1,
    .core_pchigh);

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // event counters: 0 entry, 1 vector, 2 restore, 3 wake
  always @(posedge pclk) begin
    if (stack_push === 1'b1) cnt[0]++;
    if (vector_load === 1'b1) cnt[1]++;
    if (vector_load === 1'b1) last_vec = vector_addr;
    if (restore_valid === 1'b1) cnt[2]++;
    if (restore_valid === 1'b1) last_rw = restore_w;
    if (core_wake === 1'b1) cnt[3]++;
  end

  task automatic test_done;
    $display("checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // shadowed status never carries the expiry and powerdown bits
  function automatic logic [7:0] saved_status(input logic [7:0] s);
    return s & ~IRCW_STATUS_KEEP_MASK;
  endfunction : saved_status

  // one idle cycle after each transfer keeps psel from being driven twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK("register read", {24'h0, e}, rd)
  endtask : rchk

  task automatic wcnt(input int i, input int t);
    for (int k = 0; k < 200 && cnt[i] < t; k++) @(posedge pclk);
    `CHK("event count", t, cnt[i])
  endtask : wcnt

  task automatic ret_pulse(input int t);
    core_return_from_irq <= 1'b1;
    @(posedge pclk);
    core_return_from_irq <= 1'b0;
    wcnt(2, t);
  endtask : ret_pulse

  task automatic sleep_pulse;
    core_sleep <= 1'b1;
    @(posedge pclk);
    core_sleep <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : sleep_pulse

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    test_done;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 55507;
    {psel, penable, pwrite, ext_irq_pin, timer0_overflow, pin_change_any} = 6'h00;
    {core_sleep, core_return_from_irq, mutate, presetn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    periph_flags = 8'h00;
    errors = 0;
    num_checks = 0;
    cnt = '{default: 0};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rchk(IRCW_OFS_CONTROL, 8'h00);
    rchk(IRCW_OFS_PIE_ONE, 8'h00);
    for (int i = 0; i < 6; i++) begin
      r = 8'($random(seed));
      apb(1'b1, IRCW_OFS_PIE_ONE, r);
      rchk(IRCW_OFS_PIE_ONE, r);
    end
    apb(1'b1, IRCW_OFS_PIE_ONE, 8'h00);
    apb(1'b1, 12'h020, 8'hff);
    `CHK("unmapped error", 1'b1, err)
    apb(1'b1, IRCW_OFS_CONTROL, 8'h3f);
    rchk(IRCW_OFS_CONTROL, 8'h3e);
    apb(1'b1, IRCW_OFS_CONTROL, 8'h00);
    pin_change_any  <= 1'b1;
    timer0_overflow <= 1'b1;
    @(posedge pclk);
    timer0_overflow <= 1'b0;
    repeat (2) @(posedge pclk);
    rchk(IRCW_OFS_CONTROL, 8'h05);
    pin_change_any <= 1'b0;
    // wrong edge, right edge, then a steady pin, for each polarity
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, IRCW_OFS_OPTION, 8'(p));
      ext_irq_pin <= p[0];
      repeat (10) @(posedge pclk);
      apb(1'b1, IRCW_OFS_CONTROL, 8'h00);
      ext_irq_pin <= !p[0];
      repeat (10) @(posedge pclk);
      rchk(IRCW_OFS_CONTROL, 8'h00);
      ext_irq_pin <= p[0];
      repeat (10) @(posedge pclk);
      rchk(IRCW_OFS_CONTROL, 8'h02);
      apb(1'b1, IRCW_OFS_CONTROL, 8'h00);
      repeat (10) @(posedge pclk);
      rchk(IRCW_OFS_CONTROL, 8'h00);
    end
    ext_irq_pin <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b1, IRCW_OFS_CONTROL, 8'h00);
    apb(1'b1, IRCW_OFS_CONTROL, 8'h90);
    ext_irq_pin <= 1'b1;
    wcnt(0, 1);
    wcnt(1, 1);
    `CHK("vector", 15'h0004, last_vec)
    rchk(IRCW_OFS_CONTROL, 8'h12);
    rchk(IRCW_OFS_STATE, 8'h02);
    rchk(IRCW_OFS_SHADOW, core_w);
    rchk(IRCW_OFS_SHADOW + 12'h004, saved_status(core_status));
    r = 8'($random(seed));
    apb(1'b1, IRCW_OFS_SHADOW, r);
    rchk(IRCW_OFS_SHADOW, r);
    apb(1'b1, IRCW_OFS_CONTROL, 8'h10);
    mutate <= 1'b1;
    @(posedge pclk);
    mutate <= 1'b0;
    ret_pulse(1);
    `CHK("restored w", r, last_rw)
    rchk(IRCW_OFS_CONTROL, 8'h90);
    `CHK("restored bank", 5'h1f, core_bnk)
    `CHK("restored ptrs", {16'h1234, 16'h5678, 7'h2a}, {core_ptr0, core_ptr1, core_pchigh})
    apb(1'b1, IRCW_OFS_PIE_ONE, 8'h01);
    periph_flags <= 8'h01;
    repeat (40) @(posedge pclk);
    `CHK("entries", 1, cnt[0])
    apb(1'b1, IRCW_OFS_CONTROL, 8'hc0);
    wcnt(0, 2);
    periph_flags <= 8'h00;
    ret_pulse(2);
    ext_irq_pin <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b1, IRCW_OFS_CONTROL, 8'h50);
    sleep_pulse;
    periph_flags <= 8'h01;
    repeat (20) @(posedge pclk);
    `CHK("asleep", 1'b1, core_asleep)
    periph_flags <= 8'h00;
    ext_irq_pin <= 1'b1;
    wcnt(3, 1);
    repeat (40) @(posedge pclk);
    `CHK("entries", 2, cnt[0])
    ext_irq_pin <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b1, IRCW_OFS_CONTROL, 8'hd0);
    sleep_pulse;
    ext_irq_pin <= 1'b1;
    wcnt(3, 2);
    wcnt(0, 3);
    ret_pulse(3);
    test_done;
  end
endmodule : irq_ctrl_wake_context_test

`default_nettype wire

// ==== shared/ircw_pkg.sv ====
// package: register map, field positions, reset values and timing counts for the irq block
package ircw_pkg;

  // apb byte offsets
  localparam logic [11:0] IRCW_OFS_CONTROL   = 12'h000;
  localparam logic [11:0] IRCW_OFS_PIE_ONE   = 12'h004;
  localparam logic [11:0] IRCW_OFS_OPTION    = 12'h008;
  localparam logic [11:0] IRCW_OFS_STATE     = 12'h00c;
  localparam logic [11:0] IRCW_OFS_SHADOW    = 12'h040;
  localparam int          IRCW_SHADOW_BANK   = 31;
  localparam int          IRCW_SHADOW_NUM    = 8;

  // shadow slots
  localparam int IRCW_SH_W      = 0;
  localparam int IRCW_SH_STATUS = 1;
  localparam int IRCW_SH_BNK    = 2;
  localparam int IRCW_SH_PTR0L  = 3;
  localparam int IRCW_SH_PTR0H  = 4;
  localparam int IRCW_SH_PTR1L  = 5;
  localparam int IRCW_SH_PTR1H  = 6;
  localparam int IRCW_SH_PCHIGH = 7;

  // irq_control fields
  localparam int IRCW_B_GEN   = 7;
  localparam int IRCW_B_PEN   = 6;
  localparam int IRCW_B_T0IE  = 5;
  localparam int IRCW_B_EXTIE = 4;
  localparam int IRCW_B_PCIE  = 3;
  localparam int IRCW_B_T0IF  = 2;
  localparam int IRCW_B_EXTIF = 1;
  localparam int IRCW_B_PCIF  = 0;

  // option and state fields
  localparam int IRCW_B_EDGE_POL = 0;
  localparam int IRCW_B_ASLEEP   = 0;
  localparam int IRCW_B_IN_ISR   = 1;

  // status bits kept live on save and restore
  localparam int IRCW_B_WDT_EXPIRY = 4;
  localparam int IRCW_B_POWERDOWN  = 3;
  localparam logic [7:0] IRCW_STATUS_KEEP_MASK = 8'h18;

  localparam logic [7:0]  IRCW_RST_CONTROL = 8'h00;
  localparam logic [7:0]  IRCW_RST_PIE_ONE = 8'h00;
  localparam logic [7:0]  IRCW_RST_OPTION  = 8'h00;
  localparam logic [14:0] IRCW_VECTOR      = 15'h0004;

  // instruction cycle: four clocks of 4 ns each
  localparam int IRCW_CLK_NS       = 4;
  localparam int IRCW_INSTR_NS     = 16;
  localparam int IRCW_CLKS_PER_INS = IRCW_INSTR_NS / IRCW_CLK_NS;

  typedef enum logic [2:0] {
    IRCW_RUN, IRCW_SLEEP, IRCW_WAKE_STEP, IRCW_FLUSH, IRCW_VECTOR_LOAD
  } ircw_state_t;

endpackage : ircw_pkg

// ==== verilog/ircw_ctrl.sv ====
// design: interrupt control with wake from sleep, edge pin and context shadowing
//
// Contract
// R1: a peripheral wakes the device only if enabled before sleep and clockless-capable; control bit 6 is read live, not frozen at sleep
// R2: after wake, branch to vector when global enable set, else continue
// R3: the instruction after sleep always executes before any branch to the vector
// R4: external pin is edge triggered; polarity bit one rising, zero falling
// R5: valid edge sets external flag; redirect only with global and external enables
// R6: entering an interrupt pushes the return program counter onto the stack
// R7: entry copies accumulator, bank, pointers, pc latch, status minus expiry and powerdown
// R8: return restores from shadows; live changes lost, shadow writes take effect
// R9: shadow registers are software readable and writable in bank 31
// R10: every flag sets on its condition regardless of any enable
// R11: software should clear flags before enabling their interrupts
// R12: control bit 7 is global enable; writable control bits reset zero
// R13: control bit 6 must be set for peripheral enable register sources
// R14: control bit 2 is timer0 overflow flag, bit 5 its enable
// R15: control bit 0 is read-only pin-change flag, bit 3 its enable
// R16: control bit 1 is external flag, bit 4 external enable, both read-write
// R17: peripheral enable one holds eight read-write enables, reset zero
// R18: taking an interrupt flushes, clears global enable, pushes pc, saves, loads 0004h
// R19: return pops address, restores context and sets global enable again
// R20: latency three to four cycles synchronous, three to five asynchronous
// R21: external pin is synchronised before edge detection, one flag set per edge
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ircw_ctrl
  import ircw_pkg::*;
#(
  parameter int CLKS_PER_INSTR = IRCW_CLKS_PER_INS,
  parameter logic [7:0] PERIPH_CLOCKLESS = 8'h00,
  parameter bit TIMER0_CLOCKLESS = 1'b0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_irq_pin,
  input  wire logic        timer0_overflow,
  input  wire logic        pin_change_any,
  input  wire logic [7:0]  periph_flags,
  input  wire logic        core_sleep,
  input  wire logic        core_return_from_irq,
  input  wire logic [14:0] core_pc,
  input  wire logic [7:0]  core_w,
  input  wire logic [7:0]  core_status,
  input  wire logic [4:0]  core_bnk,
  input  wire logic [15:0] core_ptr0,
  input  wire logic [15:0] core_ptr1,
  input  wire logic [6:0]  core_pchigh,
  output logic             core_asleep,
  output logic             core_wake,
  output logic             core_instr_tick,
  output logic             core_flush,
  output logic             stack_push,
  output logic      [14:0] stack_push_pc,
  output logic             vector_load,
  output logic      [14:0] vector_addr,
  output logic             restore_valid,
  output logic      [7:0]  restore_w,
  output logic      [7:0]  restore_status,
  output logic      [4:0]  restore_bnk,
  output logic      [15:0] restore_ptr0,
  output logic      [15:0] restore_ptr1,
  output logic      [6:0]  restore_pchigh
);

  if (CLKS_PER_INSTR < 2 || CLKS_PER_INSTR > 255) begin : g_bad_div
    $error("ircw_ctrl: CLKS_PER_INSTR out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction cycle divider
  logic [7:0] div_q;
  logic       tick;

  assign tick = (div_q == 8'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
    end else if (tick) begin
      div_q <= 8'(CLKS_PER_INSTR - 1);
    end else begin
      div_q <= div_q - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_instr_tick <= 1'b0;
    end else begin
      core_instr_tick <= tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: no wait state, pready high in the first access cycle, registered answer
  logic        wr_en;
  logic [7:0]  wbyte;
  logic        addr_ok;
  logic [3:0]  sh_idx;
  logic        sh_hit;
  logic [7:0]  ctrl_q;
  logic [7:0]  pie_q;
  logic [7:0]  opt_q;
  logic [7:0]  shadow_q [IRCW_SHADOW_NUM];
  ircw_state_t st_q;
  logic        in_isr_q;

  assign wr_en  = psel & penable & pready & pwrite & ~pslverr;
  assign wbyte  = pwdata[7:0];
  assign sh_idx = 4'(paddr[5:2]);
  assign sh_hit = (paddr[11:6] == IRCW_OFS_SHADOW[11:6]) && (sh_idx < 4'(IRCW_SHADOW_NUM))
                  && (paddr[1:0] == 2'b00);
  assign addr_ok = sh_hit || paddr == IRCW_OFS_CONTROL || paddr == IRCW_OFS_PIE_ONE
                   || paddr == IRCW_OFS_OPTION || paddr == IRCW_OFS_STATE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~addr_ok;
      if (psel && !penable && !pwrite) begin
        prdata <= 32'h0000_0000;
        if (sh_hit) begin
          prdata[7:0] <= shadow_q[sh_idx[2:0]]; // R9
        end else if (paddr == IRCW_OFS_CONTROL) begin
          prdata[7:0] <= ctrl_q;
        end else if (paddr == IRCW_OFS_PIE_ONE) begin
          prdata[7:0] <= pie_q;
        end else if (paddr == IRCW_OFS_OPTION) begin
          prdata[7:0] <= opt_q;
        end else if (paddr == IRCW_OFS_STATE) begin
          prdata[IRCW_B_ASLEEP] <= (st_q == IRCW_SLEEP);
          prdata[IRCW_B_IN_ISR] <= in_isr_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external pin: three flops, level accepted when second and third agree
  logic sync1_q, sync2_q, sync3_q, ext_lvl_q;
  logic ext_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q   <= 1'b0;
      sync2_q   <= 1'b0;
      sync3_q   <= 1'b0;
      ext_lvl_q <= 1'b0;
    end else begin
      sync1_q <= ext_irq_pin; // R21
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        ext_lvl_q <= sync3_q;
      end
    end
  end

  // edge polarity chooses which transition of the filtered level counts
  assign ext_edge = (sync2_q == sync3_q) && (sync3_q != ext_lvl_q)
                    && (sync3_q == opt_q[IRCW_B_EDGE_POL]); // R4

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_q <= IRCW_RST_OPTION;
    end else if (wr_en && paddr == IRCW_OFS_OPTION) begin
      opt_q <= {7'h00, wbyte[IRCW_B_EDGE_POL]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and peripheral enable registers
  logic take;
  logic periph_pend, pending;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pie_q <= IRCW_RST_PIE_ONE; // R17
    end else if (wr_en && paddr == IRCW_OFS_PIE_ONE) begin
      pie_q <= wbyte; // R17
    end
  end

  // flag sets win over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= IRCW_RST_CONTROL; // R12
    end else begin
      if (wr_en && paddr == IRCW_OFS_CONTROL) begin
        ctrl_q[7:1] <= wbyte[7:1]; // R16
      end
      if (take) begin
        ctrl_q[IRCW_B_GEN] <= 1'b0; // R18
      end else if (core_return_from_irq && in_isr_q) begin
        ctrl_q[IRCW_B_GEN] <= 1'b1; // R19
      end
      if (timer0_overflow) begin
        ctrl_q[IRCW_B_T0IF] <= 1'b1; // R14 R10
      end
      if (ext_edge) begin
        ctrl_q[IRCW_B_EXTIF] <= 1'b1; // R5 R10
      end
      ctrl_q[IRCW_B_PCIF] <= pin_change_any; // R15
    end
  end

  assign periph_pend = ctrl_q[IRCW_B_PEN] & |(periph_flags & pie_q); // R13
  assign pending = (ctrl_q[IRCW_B_T0IE] & ctrl_q[IRCW_B_T0IF])
                 | (ctrl_q[IRCW_B_EXTIE] & ctrl_q[IRCW_B_EXTIF]) // R5
                 | (ctrl_q[IRCW_B_PCIE] & ctrl_q[IRCW_B_PCIF])
                 | periph_pend;

  ////////////////////////////////////////////////////////////////////////////
  // sleep, wake and entry sequencing
  logic [7:0] wake_pie_q;
  logic [2:0] wake_ctl_q;
  logic       wake_now;

  // enables are frozen at sleep entry except control bit 6, which is read live, so setting it later can add a peripheral wake
  assign wake_now = (wake_ctl_q[2] & ctrl_q[IRCW_B_T0IF] & TIMER0_CLOCKLESS)
                  | (wake_ctl_q[1] & ctrl_q[IRCW_B_EXTIF])
                  | (wake_ctl_q[0] & ctrl_q[IRCW_B_PCIF])
                  | (ctrl_q[IRCW_B_PEN] & |(periph_flags & wake_pie_q & PERIPH_CLOCKLESS)); // R1

  assign take = tick && ctrl_q[IRCW_B_GEN] && pending && (st_q == IRCW_RUN); // R2 R18 R20

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_pie_q <= 8'h00;
      wake_ctl_q <= 3'b000;
    end else if (core_sleep && st_q == IRCW_RUN) begin
      wake_pie_q <= pie_q; // R1
      wake_ctl_q <= {ctrl_q[IRCW_B_T0IE], ctrl_q[IRCW_B_EXTIE], ctrl_q[IRCW_B_PCIE]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= IRCW_RUN;
    end else begin
      unique case (st_q)
        IRCW_RUN: begin
          if (take) begin
            st_q <= IRCW_FLUSH;
          end else if (core_sleep) begin
            st_q <= IRCW_SLEEP;
          end
        end
        IRCW_SLEEP: begin
          if (wake_now) begin
            st_q <= IRCW_WAKE_STEP;
          end
        end
        IRCW_WAKE_STEP: begin
          // the instruction after sleep runs in this state, up to the next tick, before any branch
          if (tick) begin
            st_q <= IRCW_RUN; // R3 R2
          end
        end
        IRCW_FLUSH: begin
          if (tick) begin
            st_q <= IRCW_VECTOR_LOAD; // R20
          end
        end
        IRCW_VECTOR_LOAD: begin
          st_q <= IRCW_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_asleep   <= 1'b0;
      core_wake     <= 1'b0;
      core_flush    <= 1'b0;
      stack_push    <= 1'b0;
      stack_push_pc <= 15'h0000;
      vector_load   <= 1'b0;
      vector_addr   <= 15'h0000;
      in_isr_q      <= 1'b0;
    end else begin
      core_asleep <= (st_q == IRCW_SLEEP && !wake_now) || (st_q == IRCW_RUN && core_sleep && !take);
      core_wake   <= (st_q == IRCW_SLEEP) && wake_now;
      core_flush  <= take; // R18
      stack_push  <= take; // R6
      vector_load <= (st_q == IRCW_FLUSH) && tick; // R18
      if ((st_q == IRCW_FLUSH) && tick) begin
        vector_addr <= IRCW_VECTOR; // R18
      end
      if (take) begin
        stack_push_pc <= core_pc; // R6
        in_isr_q      <= 1'b1;
      end else if (core_return_from_irq) begin
        in_isr_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shadow registers: hardware save beats a software write in the same cycle
  logic [7:0] live [IRCW_SHADOW_NUM];

  assign live[IRCW_SH_W]      = core_w;
  assign live[IRCW_SH_STATUS] = core_status & ~IRCW_STATUS_KEEP_MASK; // R7
  assign live[IRCW_SH_BNK]    = {3'b000, core_bnk};
  assign live[IRCW_SH_PTR0L]  = core_ptr0[7:0];
  assign live[IRCW_SH_PTR0H]  = core_ptr0[15:8];
  assign live[IRCW_SH_PTR1L]  = core_ptr1[7:0];
  assign live[IRCW_SH_PTR1H]  = core_ptr1[15:8];
  assign live[IRCW_SH_PCHIGH] = {1'b0, core_pchigh};

  for (genvar i = 0; i < IRCW_SHADOW_NUM; i++) begin : g_shadow
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        shadow_q[i] <= 8'h00;
      end else if (take) begin
        shadow_q[i] <= live[i]; // R7
      end else if (wr_en && sh_hit && sh_idx == 4'(i)) begin
        shadow_q[i] <= wbyte; // R9 R8
      end
    end
  end

  // expiry and powerdown bits are taken from the live status, never restored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restore_valid  <= 1'b0;
      restore_w      <= 8'h00;
      restore_status <= 8'h00;
      restore_bnk    <= 5'h00;
      restore_ptr0   <= 16'h0000;
      restore_ptr1   <= 16'h0000;
      restore_pchigh <= 7'h00;
    end else begin
      restore_valid <= core_return_from_irq && in_isr_q; // R19
      if (core_return_from_irq && in_isr_q) begin
        restore_w      <= shadow_q[IRCW_SH_W]; // R8
        restore_status <= (shadow_q[IRCW_SH_STATUS] & ~IRCW_STATUS_KEEP_MASK)
                          | (core_status & IRCW_STATUS_KEEP_MASK);
        restore_bnk    <= shadow_q[IRCW_SH_BNK][4:0];
        restore_ptr0   <= {shadow_q[IRCW_SH_PTR0H], shadow_q[IRCW_SH_PTR0L]};
        restore_ptr1   <= {shadow_q[IRCW_SH_PTR1H], shadow_q[IRCW_SH_PTR1L]};
        restore_pchigh <= shadow_q[IRCW_SH_PCHIGH][6:0];
      end
    end
  end

endmodule : ircw_ctrl

`default_nettype wire
